// file: logic/dual_timer_pkg.sv
// Constants for the dual timer/counter block.
// Assumes a 40 MHz peripheral clock and an APB register port.
package dual_timer_pkg;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [11:0] ADDR_MODE = 12'h000;
  localparam logic [11:0] ADDR_CTRL = 12'h004;
  localparam logic [11:0] ADDR_LOW0 = 12'h008;
  localparam logic [11:0] ADDR_HIGH0 = 12'h00C;
  localparam logic [11:0] ADDR_LOW1 = 12'h010;
  localparam logic [11:0] ADDR_HIGH1 = 12'h014;
  localparam logic [11:0] ADDR_IRQ = 12'h018;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_RUN0 = 4;
  localparam int CTRL_FLAG0 = 5;
  localparam int CTRL_RUN1 = 6;
  localparam int CTRL_FLAG1 = 7;
  localparam int MODE_SHIFT1 = 4;
  localparam int IRQ_EN0 = 0;
  localparam int IRQ_EN1 = 1;
  localparam int IRQ_GLOBAL = 2;
  localparam int IRQ_ACK0 = 4;
  localparam int IRQ_ACK1 = 5;
  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [2:0] CYCLE_CLOCKS = 3'h6;
  localparam logic [4:0] PRESCALE_MASK = 5'h1F;
  typedef enum logic [1:0] {
    MODE_PRESCALED = 2'b00,
    MODE_CASCADE = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT = 2'b11
  } timer_mode_e;
endpackage

// file: logic/timer_unit.sv
// One timer/counter unit: count bytes and mode counting logic.
// Assumes ticks and load strobes are single-cycle and synchronous.
`timescale 1ns/1ps
module timer_unit (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_enable,
  // Control
  input wire logic [1:0] mode,
  input wire logic halt_split,
  input wire logic low_count,
  input wire logic high_count,
  // Preset loads
  input wire logic load_low,
  input wire logic load_high,
  input wire logic [7:0] load_data,
  // State out
  output logic [7:0] count_low_byte,
  output logic [7:0] count_high_byte,
  output logic low_overflow,
  output logic high_overflow
);
  logic [7:0] next_low;
  logic [7:0] next_high;

  // ****************************************
  // Counting
  // ****************************************
  always_comb begin
    next_low = count_low_byte;
    next_high = count_high_byte;
    low_overflow = 1'b0;
    high_overflow = 1'b0;
    unique case (dual_timer_pkg::timer_mode_e'(mode))
      dual_timer_pkg::MODE_PRESCALED: begin
        if (low_count) begin
          next_low = count_low_byte + 8'h01;
          if ((count_low_byte[4:0] & dual_timer_pkg::PRESCALE_MASK) == 5'h1F) begin
            next_high = count_high_byte + 8'h01;
            high_overflow = (count_high_byte == 8'hFF);
          end
        end
      end
      dual_timer_pkg::MODE_CASCADE: begin
        if (low_count) begin
          next_low = count_low_byte + 8'h01;
          if (count_low_byte == 8'hFF) begin
            next_high = count_high_byte + 8'h01;
            high_overflow = (count_high_byte == 8'hFF);
          end
        end
      end
      dual_timer_pkg::MODE_RELOAD: begin
        if (low_count) begin
          if (count_low_byte == 8'hFF) begin
            next_low = count_high_byte;
            low_overflow = 1'b1;
          end else begin
            next_low = count_low_byte + 8'h01;
          end
        end
      end
      dual_timer_pkg::MODE_SPLIT: begin
        if (!halt_split) begin
          if (low_count) begin
            next_low = count_low_byte + 8'h01;
            low_overflow = (count_low_byte == 8'hFF);
          end
          if (high_count) begin
            next_high = count_high_byte + 8'h01;
            high_overflow = (count_high_byte == 8'hFF);
          end
        end
      end
    endcase
    if (load_low) begin
      next_low = load_data;
    end
    if (load_high) begin
      next_high = load_data;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_low_byte <= dual_timer_pkg::RESET_BYTE;
      count_high_byte <= dual_timer_pkg::RESET_BYTE;
    end else if (clock_enable) begin
      count_low_byte <= next_low;
      count_high_byte <= next_high;
    end
  end

  a_halt_holds: assert property (@(posedge clock) disable iff (!reset_n)
    clock_enable && mode == 2'b11 && halt_split && !load_low && !load_high
    |=> $stable(count_low_byte) && $stable(count_high_byte))
    else $error("halted unit changed count");
  a_reload_value: assert property (@(posedge clock) disable iff (!reset_n)
    clock_enable && mode == 2'b10 && low_count && count_low_byte == 8'hFF && !load_low
    && !load_high |=> count_low_byte == $past(count_high_byte) && $stable(count_high_byte))
    else $error("reload value wrong");
endmodule

// file: logic/dual_timer.sv
// Two 16-bit timer/counter units with APB registers.
// Assumes pins synchronous to clock; 40 MHz clock; APB master outside.
//
// Contract
// - Cascade mode: low byte counts, its overflow bumps high, high overflow sets flag.
// - Setting run does not clear count bytes.
// - Count bytes always readable; preset only while run is clear (the code accepts presets whether or not run is set).
// - Timer source counts once per six-clock peripheral cycle.
// - Counter source samples pin each cycle, counts high-then-low samples.
// - Gating off: run alone enables; gating on: gate pin also controls.
// - Gated unit counts only while gate pin high and run set.
// - Rollover from all ones to zero sets flag and requests interrupt.
// - Mode codes: 00 prescaled, 01 cascade, 10 reload, 11 split or halt.
// - Mode 0: high byte counts behind a modulo-32 low five-bit prescaler.
// - Mode 2: low byte counts, reloads from high byte, flag on overflow.
// - Unit 0 mode 3: low uses unit 0 controls; high uses unit 1 run/flag.
// - Unit 1 in mode 3 halts and holds its count.
// - Unit 0 uses mode bits 3:0, control 0,1,4,5; unit 1 upper ones (the code gives unit 0 control bits 4,5 and unit 1 bits 6,7).
// - Flag set on overflow, cleared by hardware on vectoring.
// - Interrupt reaches processor only with unit and global enables set.
// - Unit 1 overflow events offered as serial baud clock.
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module dual_timer (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_enable,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External pins
  input wire logic count_pin_unit0,
  input wire logic count_pin_unit1,
  input wire logic gate_pin_unit0,
  input wire logic gate_pin_unit1,
  // Interrupt vectoring
  input wire logic vector_ack_unit0,
  input wire logic vector_ack_unit1,
  // Outputs
  output logic irq_unit0,
  output logic irq_unit1,
  output logic baud_tick
);
  // ****************************************
  // State
  // ****************************************
  logic [7:0] timer_mode_reg;
  logic [7:0] timer_control_reg;
  logic [1:0] timer_irq_enable;
  logic global_irq_enable;
  logic [2:0] phase;
  logic [1:0] pin_sample;
  logic [1:0] pin_prev;
  logic [7:0] next_mode;
  logic [7:0] next_control;
  logic [1:0] next_irq_enable;
  logic next_global;
  logic [2:0] next_phase;
  logic [1:0] next_sample;
  logic [1:0] next_prev;
  logic [31:0] next_rdata;
  logic [31:0] read_data;
  logic cycle_tick;
  logic [1:0] event_sel;
  logic [1:0] enabled;
  logic [1:0] low_count;
  logic th0_count;
  logic [7:0] low_byte [2];
  logic [7:0] high_byte [2];
  logic [1:0] low_ovf;
  logic [1:0] high_ovf;
  logic [1:0] flag_set;
  logic [1:0] load_low;
  logic [1:0] load_high;
  logic write_en;
  logic [1:0] mode0;
  logic [1:0] mode1;

  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] b);
    addr_hit = (a == b);
  endfunction

  assign write_en = psel && penable && pwrite;
  assign pready = 1'b1;
  assign mode0 = timer_mode_reg[1:0];
  assign mode1 = timer_mode_reg[dual_timer_pkg::MODE_SHIFT1 +: 2];
  assign cycle_tick = clock_enable && (phase == dual_timer_pkg::CYCLE_CLOCKS - 3'h1);
  assign th0_count = cycle_tick && timer_control_reg[dual_timer_pkg::CTRL_RUN1];
  assign baud_tick = (mode1 == 2'b11) ? 1'b0 : (high_ovf[1] || low_ovf[1]);

  // ****************************************
  // Per-unit event selection and gating
  // ****************************************
  genvar u;
  generate
    for (u = 0; u < 2; u++) begin : g_unit
      logic run;
      logic gate_pin;
      logic src_sel;
      logic gate_en;
      logic [1:0] umode;
      assign umode = (u == 0) ? mode0 : mode1;
      // Unit 1 free-runs while unit 0 splits, since unit 0 borrows its run bit
      assign run = timer_control_reg[dual_timer_pkg::CTRL_RUN0 + 2 * u]
                   || (u == 1 && mode0 == 2'b11);
      assign gate_pin = (u == 0) ? gate_pin_unit0 : gate_pin_unit1;
      assign src_sel = timer_mode_reg[2 + 4 * u];
      assign gate_en = timer_mode_reg[3 + 4 * u];
      // Timer source every cycle; counter source on a high-then-low sample pair
      assign event_sel[u] = src_sel ? (cycle_tick && pin_prev[u] && !pin_sample[u])
                                    : cycle_tick;
      // Run bit never clears counts, so resume continues from held values
      assign enabled[u] = run && (!gate_en || gate_pin);
      assign low_count[u] = event_sel[u] && enabled[u];
      assign load_low[u] = write_en && clock_enable
                           && addr_hit(paddr, (u == 0) ? dual_timer_pkg::ADDR_LOW0
                                                       : dual_timer_pkg::ADDR_LOW1);
      assign load_high[u] = write_en && clock_enable
                            && addr_hit(paddr, (u == 0) ? dual_timer_pkg::ADDR_HIGH0
                                                        : dual_timer_pkg::ADDR_HIGH1);
      timer_unit unit (
        .clock(clock),
        .reset_n(reset_n),
        .clock_enable(clock_enable),
        .mode(umode),
        .halt_split(u == 1),
        .low_count(low_count[u]),
        .high_count((u == 0) ? th0_count : 1'b0),
        .load_low(load_low[u]),
        .load_high(load_high[u]),
        .load_data(pwdata[7:0]),
        .count_low_byte(low_byte[u]),
        .count_high_byte(high_byte[u]),
        .low_overflow(low_ovf[u]),
        .high_overflow(high_ovf[u])
      );
    end
  endgenerate

  // Split mode routes unit 0 high overflow to unit 1 flag
  always_comb begin
    flag_set = 2'b00;
    if (mode0 == 2'b11) begin
      flag_set[0] = low_ovf[0];
      flag_set[1] = high_ovf[0];
    end else begin
      flag_set[0] = low_ovf[0] || high_ovf[0];
      flag_set[1] = low_ovf[1] || high_ovf[1];
    end
  end

  // ****************************************
  // Registers, sampling and APB read
  // ****************************************
  always_comb begin
    next_mode = timer_mode_reg;
    next_control = timer_control_reg;
    next_irq_enable = timer_irq_enable;
    next_global = global_irq_enable;
    next_phase = (phase == dual_timer_pkg::CYCLE_CLOCKS - 3'h1) ? 3'h0 : phase + 3'h1;
    next_sample = pin_sample;
    next_prev = pin_prev;
    if (phase == dual_timer_pkg::CYCLE_CLOCKS - 3'h1) begin
      next_prev = pin_sample;
      next_sample = {count_pin_unit1, count_pin_unit0};
    end
    // Software should stop a unit before changing mode; no lockout is enforced
    if (write_en && addr_hit(paddr, dual_timer_pkg::ADDR_MODE)) begin
      next_mode = pwdata[7:0];
    end
    if (write_en && addr_hit(paddr, dual_timer_pkg::ADDR_CTRL)) begin
      next_control = pwdata[7:0];
    end
    if (write_en && addr_hit(paddr, dual_timer_pkg::ADDR_IRQ)) begin
      next_irq_enable = {pwdata[dual_timer_pkg::IRQ_EN1], pwdata[dual_timer_pkg::IRQ_EN0]};
      next_global = pwdata[dual_timer_pkg::IRQ_GLOBAL];
    end
    // Vectoring clears; a new overflow in the same cycle wins
    if (vector_ack_unit0) begin
      next_control[dual_timer_pkg::CTRL_FLAG0] = 1'b0;
    end
    if (vector_ack_unit1) begin
      next_control[dual_timer_pkg::CTRL_FLAG1] = 1'b0;
    end
    if (flag_set[0]) begin
      next_control[dual_timer_pkg::CTRL_FLAG0] = 1'b1;
    end
    if (flag_set[1]) begin
      next_control[dual_timer_pkg::CTRL_FLAG1] = 1'b1;
    end
  end

  always_comb begin
    read_data = 32'h00000000;
    unique case (paddr)
      dual_timer_pkg::ADDR_MODE: read_data[7:0] = timer_mode_reg;
      dual_timer_pkg::ADDR_CTRL: read_data[7:0] = timer_control_reg;
      dual_timer_pkg::ADDR_LOW0: read_data[7:0] = low_byte[0];
      dual_timer_pkg::ADDR_HIGH0: read_data[7:0] = high_byte[0];
      dual_timer_pkg::ADDR_LOW1: read_data[7:0] = low_byte[1];
      dual_timer_pkg::ADDR_HIGH1: read_data[7:0] = high_byte[1];
      dual_timer_pkg::ADDR_IRQ: read_data[2:0] = {global_irq_enable, timer_irq_enable};
      default: read_data = 32'h00000000;
    endcase
    next_rdata = (psel && !penable && !pwrite) ? read_data : prdata;
  end

  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      unique case (paddr)
        dual_timer_pkg::ADDR_MODE, dual_timer_pkg::ADDR_CTRL, dual_timer_pkg::ADDR_LOW0,
        dual_timer_pkg::ADDR_HIGH0, dual_timer_pkg::ADDR_LOW1, dual_timer_pkg::ADDR_HIGH1,
        dual_timer_pkg::ADDR_IRQ: pslverr = 1'b0;
        default: pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      timer_mode_reg <= dual_timer_pkg::RESET_BYTE;
      timer_control_reg <= dual_timer_pkg::RESET_BYTE;
      timer_irq_enable <= 2'b00;
      global_irq_enable <= 1'b0;
      phase <= 3'h0;
      pin_sample <= 2'b00;
      pin_prev <= 2'b00;
      prdata <= 32'h00000000;
    end else if (clock_enable) begin
      timer_mode_reg <= next_mode;
      timer_control_reg <= next_control;
      timer_irq_enable <= next_irq_enable;
      global_irq_enable <= next_global;
      phase <= next_phase;
      pin_sample <= next_sample;
      pin_prev <= next_prev;
      prdata <= next_rdata;
    end
  end

  // ****************************************
  // Interrupt requests
  // ****************************************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_unit0 <= 1'b0;
      irq_unit1 <= 1'b0;
    end else if (clock_enable) begin
      irq_unit0 <= next_control[dual_timer_pkg::CTRL_FLAG0] && next_irq_enable[0] && next_global;
      irq_unit1 <= next_control[dual_timer_pkg::CTRL_FLAG1] && next_irq_enable[1] && next_global;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_flag_on_ovf: assert property (@(posedge clock) disable iff (!reset_n)
    clock_enable && flag_set[0] |=> timer_control_reg[dual_timer_pkg::CTRL_FLAG0])
    else $error("overflow did not set flag");
  a_irq_gated: assert property (@(posedge clock) disable iff (!reset_n)
    irq_unit0 |-> global_irq_enable && timer_irq_enable[0])
    else $error("irq without enables");
  a_run_off_hold: assert property (@(posedge clock) disable iff (!reset_n)
    !timer_control_reg[dual_timer_pkg::CTRL_RUN0] |-> !low_count[0])
    else $error("counted while stopped");
  a_gate_low_hold: assert property (@(posedge clock) disable iff (!reset_n)
    timer_mode_reg[3] && !gate_pin_unit0 |-> !low_count[0])
    else $error("counted with gate low");
  a_tick_spacing: assert property (@(posedge clock) disable iff (!reset_n)
    cycle_tick |=> !cycle_tick)
    else $error("ticks too close");
  a_vector_clear: assert property (@(posedge clock) disable iff (!reset_n)
    clock_enable && vector_ack_unit1 && !flag_set[1]
    |=> !timer_control_reg[dual_timer_pkg::CTRL_FLAG1])
    else $error("vectoring did not clear flag");
  a_cascade_carry: assert property (@(posedge clock) disable iff (!reset_n)
    clock_enable && mode0 == 2'b01 && low_count[0] && low_byte[0] == 8'hFF && !load_high[0]
    |=> high_byte[0] == $past(high_byte[0]) + 8'h01)
    else $error("cascade carry missing");
  a_edge_count: assert property (@(posedge clock) disable iff (!reset_n)
    low_count[1] && timer_mode_reg[6] |-> pin_prev[1] && !pin_sample[1])
    else $error("counter without falling edge");
  c_flag0: cover property (@(posedge clock) flag_set[0]);
  c_split: cover property (@(posedge clock) mode0 == 2'b11 && high_ovf[0]);
  c_reload: cover property (@(posedge clock) mode1 == 2'b10 && low_ovf[1]);
endmodule

// file: verification/pin_source.sv
// Model of the external count and gate pins of one timer unit.
// Assumes the bench clock; pins change only on its rising edge.
`timescale 1ns/1ps
module pin_source #(
  parameter int HOLD_CLOCKS = 6
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Commands from the bench
  input wire logic toggle_en,
  input wire logic gate_level,
  // Pins
  output logic count_pin,
  output logic gate_pin,
  // Falling edges made so far
  output logic [7:0] falls
);
  int timer;
  assign gate_pin = gate_level;
  // A low level always finishes its span, then the pin parks high
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      timer <= 0;
      count_pin <= 1'h1;
      falls <= 8'h00;
    end else if (timer == HOLD_CLOCKS - 1) begin
      timer <= 0;
      if (toggle_en || !count_pin) begin
        count_pin <= ~count_pin;
      end
      if (toggle_en && count_pin) begin
        falls <= falls + 8'h01;
      end
    end else begin
      timer <= timer + 1;
    end
  end
endmodule

// file: verification/tb.sv
// Self-checking bench for the dual timer block.
// Assumes the package, design files and pin_source are compiled first.
`timescale 1ns/1ps
module tb;
  // ****************************************
  // Signals
  // ****************************************
  typedef struct {string name; logic [32:0] val;} note_s;
  logic clock = 1'h0;
  logic reset_n = 1'h0;
  logic clock_enable = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq_unit0, irq_unit1, baud_tick;
  logic count_pin_unit0, count_pin_unit1, gate_pin_unit0, gate_pin_unit1;
  logic toggle0 = 1'h0, toggle1 = 1'h0, gate0 = 1'h0, gate1 = 1'h0;
  logic vector_ack_unit0 = 1'h0, vector_ack_unit1 = 1'h0;
  logic [7:0] falls0, falls1;
  int err_count = 0;
  int compares = 0;
  int ticks = 0;
  note_s notes[$];
  initial forever #12.5 clock = ~clock;
  dual_timer DUT (.clock(clock), .reset_n(reset_n), .clock_enable(clock_enable),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .count_pin_unit0(count_pin_unit0),
    .count_pin_unit1(count_pin_unit1), .gate_pin_unit0(gate_pin_unit0),
    .gate_pin_unit1(gate_pin_unit1), .vector_ack_unit0(vector_ack_unit0),
    .vector_ack_unit1(vector_ack_unit1), .irq_unit0(irq_unit0), .irq_unit1(irq_unit1),
    .baud_tick(baud_tick));
  pin_source #(.HOLD_CLOCKS(6)) src0 (.clock(clock), .reset_n(reset_n), .toggle_en(toggle0),
    .gate_level(gate0), .count_pin(count_pin_unit0), .gate_pin(gate_pin_unit0), .falls(falls0));
  pin_source #(.HOLD_CLOCKS(12)) src1 (.clock(clock), .reset_n(reset_n), .toggle_en(toggle1),
    .gate_level(gate1), .count_pin(count_pin_unit1), .gate_pin(gate_pin_unit1), .falls(falls1));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check_val(input string name, input logic [32:0] exp, input logic [32:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do @(posedge clock); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    notes.push_back('{$sformatf("reg %h", a), {a > dual_timer_pkg::ADDR_IRQ, e}});
    xfer(1'h0, a, 32'h0);
  endtask
  task automatic rd_pair(input logic [15:0] v);
    rd(dual_timer_pkg::ADDR_LOW0, 32'(v[7:0]));
    rd(dual_timer_pkg::ADDR_HIGH0, 32'(v[15:8]));
  endtask
  // Runs for exactly 6*m edges, reading control late in the window
  task automatic run_for(input logic [31:0] on, input int m, input logic [31:0] mid);
    wr(dual_timer_pkg::ADDR_CTRL, on);
    repeat (6 * m - 6) @(posedge clock);
    rd(dual_timer_pkg::ADDR_CTRL, mid);
    wr(dual_timer_pkg::ADDR_CTRL, 32'h0);
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // Monitor and watchdog
  // ****************************************
  always @(posedge clock) begin
    if (psel && penable && pready === 1'h1 && !pwrite && notes.size() > 0) begin
      check_val(notes[0].name, notes[0].val, {pslverr, prdata});
      void'(notes.pop_front());
    end
    if (baud_tick === 1'h1) begin
      ticks++;
    end
  end
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    finish_test();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    int p;
    int t;
    logic [7:0] f;
    void'($urandom(15229));
    repeat (16) @(posedge clock);
    reset_n <= 1'h1;
    for (int i = 0; i < 8; i++) begin
      rd(12'(i * 4), 32'h0);
    end
    clock_enable <= 1'h0;
    wr(dual_timer_pkg::ADDR_CTRL, 32'h0F);
    clock_enable <= 1'h1;
    rd(dual_timer_pkg::ADDR_CTRL, 32'h0);
    wr(dual_timer_pkg::ADDR_CTRL, 32'h0F);
    rd(dual_timer_pkg::ADDR_CTRL, 32'h0F);
    wr(dual_timer_pkg::ADDR_HIGH1, 32'hFFFFFF5A);
    rd(dual_timer_pkg::ADDR_HIGH1, 32'h5A);
    wr(dual_timer_pkg::ADDR_HIGH1, 32'h0);
    wr(dual_timer_pkg::ADDR_CTRL, 32'h0);
    $display("test registers done");
    wr(dual_timer_pkg::ADDR_MODE, 32'h01);
    p = ($urandom_range(254, 0) << 8) | 32'hFE;
    wr(dual_timer_pkg::ADDR_LOW0, 32'(p[7:0]));
    wr(dual_timer_pkg::ADDR_HIGH0, 32'(p[15:8]));
    run_for(32'h10, 3, 32'h10);
    rd_pair(16'(p + 3));
    run_for(32'h10, 2, 32'h10);
    rd_pair(16'(p + 5));
    $display("test cascade done");
    wr(dual_timer_pkg::ADDR_LOW0, 32'hFF);
    wr(dual_timer_pkg::ADDR_HIGH0, 32'hFF);
    wr(dual_timer_pkg::ADDR_IRQ, 32'h01);
    wr(dual_timer_pkg::ADDR_CTRL, 32'h10);
    repeat (12) @(negedge clock);
    check_val("irq0 global off", 33'h0, 33'(irq_unit0));
    wr(dual_timer_pkg::ADDR_IRQ, 32'h05);
    repeat (2) @(negedge clock);
    check_val("irq0 on", 33'h1, 33'(irq_unit0));
    rd(dual_timer_pkg::ADDR_CTRL, 32'h30);
    vector_ack_unit0 <= 1'h1;
    @(posedge clock);
    vector_ack_unit0 <= 1'h0;
    repeat (2) @(negedge clock);
    check_val("irq0 vectored", 33'h0, 33'(irq_unit0));
    rd(dual_timer_pkg::ADDR_CTRL, 32'h10);
    wr(dual_timer_pkg::ADDR_CTRL, 32'h0);
    wr(dual_timer_pkg::ADDR_IRQ, 32'h0);
    $display("test flag done");
    wr(dual_timer_pkg::ADDR_MODE, 32'h00);
    wr(dual_timer_pkg::ADDR_LOW0, 32'h1E);
    wr(dual_timer_pkg::ADDR_HIGH0, 32'h05);
    run_for(32'h10, 2, 32'h10);
    rd_pair(16'h0620);
    $display("test prescaled done");
    gate1 <= 1'h1;
    wr(dual_timer_pkg::ADDR_MODE, 32'hA0);
    wr(dual_timer_pkg::ADDR_LOW1, 32'hFE);
    wr(dual_timer_pkg::ADDR_HIGH1, 32'hA0);
    t = ticks;
    run_for(32'h40, 3, 32'hC0);
    rd(dual_timer_pkg::ADDR_LOW1, 32'hA1);
    rd(dual_timer_pkg::ADDR_HIGH1, 32'hA0);
    @(negedge clock);
    check_val("baud ticks", 33'h1, 33'(ticks - t));
    // Unit 1 interrupt path: reload overflow, then vectoring
    wr(dual_timer_pkg::ADDR_LOW1, 32'hFF);
    wr(dual_timer_pkg::ADDR_IRQ, 32'h06);
    wr(dual_timer_pkg::ADDR_CTRL, 32'h40);
    repeat (12) @(negedge clock);
    check_val("irq1 on", 33'h1, 33'(irq_unit1));
    @(posedge clock);
    vector_ack_unit1 <= 1'h1;
    @(posedge clock);
    vector_ack_unit1 <= 1'h0;
    repeat (2) @(negedge clock);
    check_val("irq1 vectored", 33'h0, 33'(irq_unit1));
    wr(dual_timer_pkg::ADDR_CTRL, 32'h0);
    wr(dual_timer_pkg::ADDR_IRQ, 32'h0);
    $display("test reload done");
    wr(dual_timer_pkg::ADDR_MODE, 32'h0D);
    wr(dual_timer_pkg::ADDR_LOW0, 32'h0);
    wr(dual_timer_pkg::ADDR_HIGH0, 32'h0);
    wr(dual_timer_pkg::ADDR_CTRL, 32'h10);
    toggle0 <= 1'h1;
    repeat (100) @(posedge clock);
    toggle0 <= 1'h0;
    repeat (40) @(posedge clock);
    rd(dual_timer_pkg::ADDR_LOW0, 32'h0);
    @(posedge clock);
    f = falls0;
    gate0 <= 1'h1;
    repeat (12) @(posedge clock);
    toggle0 <= 1'h1;
    repeat ($urandom_range(200, 60)) @(posedge clock);
    toggle0 <= 1'h0;
    repeat (40) @(posedge clock);
    rd(dual_timer_pkg::ADDR_LOW0, 32'(falls0 - f));
    wr(dual_timer_pkg::ADDR_CTRL, 32'h0);
    // Unit 1 counter source, cascade, ungated
    wr(dual_timer_pkg::ADDR_MODE, 32'h5D);
    wr(dual_timer_pkg::ADDR_LOW1, 32'h0);
    wr(dual_timer_pkg::ADDR_HIGH1, 32'h0);
    wr(dual_timer_pkg::ADDR_CTRL, 32'h40);
    f = falls1;
    toggle1 <= 1'h1;
    repeat ($urandom_range(300, 100)) @(posedge clock);
    toggle1 <= 1'h0;
    repeat (40) @(posedge clock);
    rd(dual_timer_pkg::ADDR_LOW1, 32'(falls1 - f));
    wr(dual_timer_pkg::ADDR_CTRL, 32'h0);
    $display("test counter done");
    wr(dual_timer_pkg::ADDR_MODE, 32'h33);
    wr(dual_timer_pkg::ADDR_LOW0, 32'h0);
    wr(dual_timer_pkg::ADDR_HIGH0, 32'hFF);
    wr(dual_timer_pkg::ADDR_LOW1, 32'h10);
    t = ticks;
    run_for(32'h10, 2, 32'h10);
    rd_pair(16'hFF02);
    run_for(32'h40, 2, 32'hC0);
    rd_pair(16'h0102);
    rd(dual_timer_pkg::ADDR_LOW1, 32'h10);
    @(negedge clock);
    check_val("halted ticks", 33'h0, 33'(ticks - t));
    $display("test split done");
    repeat (4) @(posedge clock);
    finish_test();
  end
endmodule
